/* pct_pkg.sv */
// Purpose: constants and types for the phase comparison trip timing block
// Assumes: 50 MHz clk, Avalon-MM register slave with waitrequest
// Notes: timer settings are in microseconds in registers; counts derive from the rate
// What this block does
// - With no high-set detector output on a balanced three-phase fault, mho trip stands in as fault indication and comparer enable.
// - On three-phase faults mho block stands in for the low-set detector for carrier start and keying supervision.
// - During three-phase faults the positive-sequence part drives the squaring and medium-set inputs.
// - Fault indication held for setting A with no persistence timer output sets the blocking timer output.
// - The blocking timer output inhibits all tripping until setting B after fault indication drops.
// - On an internal fault the persistence timer output inhibits the trip path gate feeding the blocking timer.
// - Setting A must exceed the longest internal-fault operating time so blocking only sets on external faults.
// - Transmitter keying passes a symmetry timer with separate pickup and dropout delays of 0 to 3 ms.
// - A phase delay timer with 0 to 8 ms pickup and dropout sits between the keying supervision gate and the comparer.
// - The phase delay setting equals the channel delay, 1 to 5 ms.
// - Squared signal keys the transmitter off and trips only with medium-set and low-set outputs also present.
// - The comparer asserts only with delayed keying and fault indication (high-set or mho trip) present and no carrier received.
// - The trip output rises only after the comparer holds for at least 3 ms continuously.
package pct_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int TRIP_PERSIST_US = 3000;
   localparam logic [23:0] TRIP_PERSIST_CYC = 24'(TRIP_PERSIST_US * CYC_PER_US);
   localparam int SYM_MAX_US = 3000;
   localparam int PHASE_MAX_US = 8000;
   localparam int CHAN_MIN_US = 1000;
   localparam int CHAN_MAX_US = 5000;
   localparam int BLK_A_RST_US = 18000;
   localparam int BLK_B_RST_US = 18000;
   localparam int PHASE_RST_US = 3000;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h02;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h03;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
   localparam logic [7:0] ADDR_BLK_A = 8'h05;
   localparam logic [7:0] ADDR_BLK_B = 8'h06;
   localparam logic [7:0] ADDR_SYM_PU = 8'h07;
   localparam logic [7:0] ADDR_SYM_DO = 8'h08;
   localparam logic [7:0] ADDR_PH_PU = 8'h09;
   localparam logic [7:0] ADDR_PH_DO = 8'h0A;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_3PH_BIT = 1;
   localparam int NUM_EVT = 3;
   localparam int EVT_TRIP = 0;
   localparam int EVT_BLOCK = 1;
   localparam int EVT_FAULT = 2;
   localparam logic [31:0] SET_MAX_US = 32'h0000_FFFF;
   typedef enum {PCT_IDLE, PCT_ACK} pct_bus_t;
endpackage : pct_pkg

/* pct_tmr_if.sv */
// Purpose: carrier between top and a pickup/dropout timer
// Assumes: one clock domain
// Notes: counts in clock cycles
interface pct_tmr_if;
   logic din;
   logic [23:0] pu_cyc;
   logic [23:0] do_cyc;
   logic dout;
   modport owner (output din, output pu_cyc, output do_cyc, input dout);
   modport timer (input din, input pu_cyc, input do_cyc, output dout);
endinterface : pct_tmr_if

/* pct_pudo_timer.sv */
// Purpose: pickup/dropout delay timer
// Assumes: synchronous active-high reset
// Notes: zero count passes the edge on the next cycle
module pct_pudo_timer
   import pct_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   pct_tmr_if.timer t
);
   logic [23:0] cnt;
   logic q;
   assign t.dout = q;
   // counter chases the input, output flips once the proper delay has run
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 24'h000000;
         q <= 1'b0;
      end else if (t.din == q) begin
         cnt <= 24'h000000;
      end else if ((q == 1'b0 && cnt >= t.pu_cyc) || (q == 1'b1 && cnt >= t.do_cyc)) begin
         q <= t.din;
         cnt <= 24'h000000;
      end else begin
         cnt <= cnt + 24'h000001;
      end
   end
   a_pickup_delay: assert property (@(posedge clk) disable iff (rst)
      $rose(q) |-> $past(t.din))
      else $error("timer rose without input");
endmodule : pct_pudo_timer

/* pct_trip_timing.sv */
// Purpose: phase comparison trip timing and transient blocking
// Assumes: detector inputs synchronous to clk; settings in microseconds
// Notes: four pickup/dropout timers share one timer module
module pct_trip_timing
   import pct_pkg::*;
#(
   // persistence pickup in cycles; a bench may shorten it, hardware keeps 3 ms
   parameter logic [23:0] PERSIST_CYC = TRIP_PERSIST_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic high_set_fault_detector,
   input wire logic low_set_fault_detector,
   input wire logic medium_set_detector,
   input wire logic mho_trip_function,
   input wire logic mho_block_function,
   input wire logic squared_neg_seq,
   input wire logic squared_pos_seq,
   input wire logic medium_set_pos_seq,
   input wire logic carrier_received,
   output logic carrier_start,
   output logic transmitter_key_off,
   output logic trip_out,
   output logic transient_blocking_function,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl;
   logic [15:0] blk_a_us, blk_b_us, sym_pu_us, sym_do_us, ph_pu_us, ph_do_us;
   logic [NUM_EVT-1:0] irq_stat, irq_en, evt;
   logic [31:0] next_rdata;
   pct_bus_t bus_st;
   logic three_ph;
   logic fault_ind, low_sup, squared, med_sup, enable;
   assign three_ph = ctrl[CTRL_3PH_BIT];

   // single-cycle waitrequest high, answer on the second edge
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_st <= PCT_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         case (bus_st)
            PCT_IDLE: begin
               avs_waitrequest <= 1'b1;
               if (avs_read || avs_write) begin
                  bus_st <= PCT_ACK;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= next_rdata;
               end
            end
            PCT_ACK: begin
               bus_st <= PCT_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: bus_st <= PCT_IDLE;
         endcase
      end
   end

   logic wr_now;
   assign wr_now = avs_write && bus_st == PCT_ACK;

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (avs_address)
         ADDR_CTRL: next_rdata = ctrl;
         ADDR_STATUS: next_rdata = {27'h0, transient_blocking_function, trip_out,
            transmitter_key_off, carrier_start, fault_ind};
         ADDR_IRQ_STAT: next_rdata = {29'h0, irq_stat};
         ADDR_IRQ_EN: next_rdata = {29'h0, irq_en};
         ADDR_BLK_A: next_rdata = {16'h0, blk_a_us};
         ADDR_BLK_B: next_rdata = {16'h0, blk_b_us};
         ADDR_SYM_PU: next_rdata = {16'h0, sym_pu_us};
         ADDR_SYM_DO: next_rdata = {16'h0, sym_do_us};
         ADDR_PH_PU: next_rdata = {16'h0, ph_pu_us};
         ADDR_PH_DO: next_rdata = {16'h0, ph_do_us};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
      merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RST;
         blk_a_us <= 16'(BLK_A_RST_US);
         blk_b_us <= 16'(BLK_B_RST_US);
         sym_pu_us <= 16'h0000;
         sym_do_us <= 16'h0000;
         ph_pu_us <= 16'(PHASE_RST_US);
         ph_do_us <= 16'(PHASE_RST_US);
         irq_en <= '0;
      end else if (wr_now) begin
         case (avs_address)
            ADDR_CTRL: ctrl <= {30'h0, avs_byteenable[0] ? avs_writedata[1:0] : ctrl[1:0]};
            ADDR_IRQ_EN: if (avs_byteenable[0]) irq_en <= avs_writedata[NUM_EVT-1:0];
            ADDR_BLK_A: blk_a_us <= merge16(blk_a_us, avs_writedata, avs_byteenable);
            ADDR_BLK_B: blk_b_us <= merge16(blk_b_us, avs_writedata, avs_byteenable);
            // symmetry delays clamp at 3 ms
            ADDR_SYM_PU: sym_pu_us <= lim(merge16(sym_pu_us, avs_writedata, avs_byteenable),
                                          16'(SYM_MAX_US));
            ADDR_SYM_DO: sym_do_us <= lim(merge16(sym_do_us, avs_writedata, avs_byteenable),
                                          16'(SYM_MAX_US));
            // phase delay clamps at 8 ms; software sets it to the channel delay
            ADDR_PH_PU: ph_pu_us <= lim(merge16(ph_pu_us, avs_writedata, avs_byteenable),
                                        16'(PHASE_MAX_US));
            ADDR_PH_DO: ph_do_us <= lim(merge16(ph_do_us, avs_writedata, avs_byteenable),
                                        16'(PHASE_MAX_US));
            default: ;
         endcase
      end
   end

   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] m);
      lim = (v > m) ? m : v;
   endfunction : lim

   function automatic logic [23:0] us2cyc(input logic [15:0] us);
      us2cyc = 24'(us) * 24'(CYC_PER_US);
   endfunction : us2cyc

   ////////////////////////////////////////////////////////////////////////////
   // detector substitution for balanced three-phase faults
   assign enable = ctrl[CTRL_ENABLE_BIT];
   assign fault_ind = high_set_fault_detector || (mho_trip_function && !high_set_fault_detector);
   assign low_sup = three_ph ? mho_block_function : low_set_fault_detector;
   assign squared = three_ph ? squared_pos_seq : squared_neg_seq;
   assign med_sup = three_ph ? medium_set_pos_seq : medium_set_detector;

   logic key_gate;
   assign key_gate = enable && squared && med_sup && low_sup;

   ////////////////////////////////////////////////////////////////////////////
   pct_tmr_if sym_if();
   pct_tmr_if ph_if();
   pct_tmr_if blk_if();
   pct_tmr_if per_if();

   assign sym_if.din = key_gate;
   assign sym_if.pu_cyc = us2cyc(sym_pu_us);
   assign sym_if.do_cyc = us2cyc(sym_do_us);
   assign ph_if.din = key_gate;
   assign ph_if.pu_cyc = us2cyc(ph_pu_us);
   assign ph_if.do_cyc = us2cyc(ph_do_us);

   // comparer: delayed keying, fault indication (high-set or mho trip), no carrier
   logic comparer;
   assign comparer = ph_if.dout && fault_ind && !carrier_received;

   // persistence timer: 3 ms pickup, no dropout stretch
   assign per_if.din = comparer;
   assign per_if.pu_cyc = PERSIST_CYC - 24'h000001;
   assign per_if.do_cyc = 24'h000000;

   // trip path gate: fault indication without persistence output
   logic trip_path_gate;
   assign trip_path_gate = fault_ind && !per_if.dout && !trip_out;
   // blocking timer picks up after A, drops out B after fault indication falls
   assign blk_if.din = transient_blocking_function ? fault_ind : trip_path_gate;
   assign blk_if.pu_cyc = us2cyc(blk_a_us);
   assign blk_if.do_cyc = us2cyc(blk_b_us);

   logic blocking_gate;
   assign blocking_gate = per_if.dout && !blk_if.dout;

   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_tmr
      if (gi == 0) pct_pudo_timer u_t (.clk(clk), .rst(rst), .t(sym_if.timer));
      else if (gi == 1) pct_pudo_timer u_t (.clk(clk), .rst(rst), .t(ph_if.timer));
      else if (gi == 2) pct_pudo_timer u_t (.clk(clk), .rst(rst), .t(blk_if.timer));
      else pct_pudo_timer u_t (.clk(clk), .rst(rst), .t(per_if.timer));
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         carrier_start <= 1'b0;
         transmitter_key_off <= 1'b0;
         trip_out <= 1'b0;
         transient_blocking_function <= 1'b0;
      end else begin
         carrier_start <= enable && low_sup;
         transmitter_key_off <= sym_if.dout;
         trip_out <= blocking_gate;
         transient_blocking_function <= blk_if.dout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic trip_d, blk_d, flt_d;
   always_ff @(posedge clk) begin
      if (rst) begin
         trip_d <= 1'b0;
         blk_d <= 1'b0;
         flt_d <= 1'b0;
      end else begin
         trip_d <= trip_out;
         blk_d <= transient_blocking_function;
         flt_d <= fault_ind;
      end
   end
   assign evt[EVT_TRIP] = trip_out && !trip_d;
   assign evt[EVT_BLOCK] = transient_blocking_function && !blk_d;
   assign evt[EVT_FAULT] = fault_ind && !flt_d;

   // sticky status, set wins over a same-cycle clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((wr_now && avs_address == ADDR_IRQ_CLR && avs_byteenable[0])
                     ? avs_writedata[NUM_EVT-1:0] : {NUM_EVT{1'b0}})) | evt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) irq <= 1'b0;
      else irq <= |(irq_stat & irq_en);
   end

   ////////////////////////////////////////////////////////////////////////////
   a_trip_blocked: assert property (@(posedge clk) disable iff (rst)
      $past(blk_if.dout) |-> !trip_out)
      else $error("trip while blocking asserted");
   a_trip_persist: assert property (@(posedge clk) disable iff (rst)
      $rose(trip_out) |-> $past(comparer, 2))
      else $error("trip without sustained comparer");
   a_comparer_gate: assert property (@(posedge clk) disable iff (rst)
      comparer |-> !carrier_received && fault_ind)
      else $error("comparer with carrier present");
   a_key_supervise: assert property (@(posedge clk) disable iff (rst)
      key_gate |-> med_sup && low_sup)
      else $error("keying without supervision");
   a_blk_needs_fault: assert property (@(posedge clk) disable iff (rst)
      $rose(transient_blocking_function) |-> $past(fault_ind, 2))
      else $error("blocking without fault");
   a_key_follows: assert property (@(posedge clk) disable iff (rst)
      transmitter_key_off |-> $past(sym_if.dout))
      else $error("key off not from symmetry timer");
   a_mho_subst: assert property (@(posedge clk) disable iff (rst)
      mho_trip_function |-> fault_ind)
      else $error("mho trip not used as fault indication");
   a_carrier_start: assert property (@(posedge clk) disable iff (rst)
      ##1 carrier_start == $past(enable && low_sup))
      else $error("carrier start mismatch");
endmodule : pct_trip_timing

/* pct_chan_model.sv */
// Purpose: carrier channel and remote terminal seen from the local relay
// Assumes: remote terminal reacts to the same fault as the local end
// Notes: DLY is the channel delay in clock cycles
module pct_chan_model #(
   parameter int DLY = 1000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic carrier_on,
   input wire logic key_off,
   input wire logic external,
   output logic carrier_received
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DLY-1:0] pipe;
   logic remote_tx;
   // through fault: remote keys carrier on while the local end keys it off
   assign remote_tx = carrier_on & (external ? key_off : ~key_off);
   always_ff @(posedge clk) begin
      if (rst) begin
         pipe <= '0;
      end else begin
         pipe <= {pipe[DLY-2:0], remote_tx};
      end
   end
   assign carrier_received = pipe[DLY-1];
endmodule : pct_chan_model

/* pct_trip_timing_test.sv */
// Purpose: self-checking bench for the phase comparison trip timing block
// Assumes: bus tasks start right after a rising edge
// Notes: settings shortened to tens of microseconds; persistence shortened by parameter
module pct_trip_timing_test
   import pct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_req;
   logic hi_set = 1'b0, lo_set = 1'b0, med = 1'b0, mho_t = 1'b0, mho_b = 1'b0;
   logic sq_neg = 1'b0, sq_pos = 1'b0, med_pos = 1'b0, ext = 1'b0;
   logic carrier_rx, carrier_start, key_off, trip, blocking, irq;
   localparam logic [23:0] PERSIST = 24'h0007D0;
   int fail_count = 0;
   int cmp_count = 0;
   int n;
   logic [31:0] rv;
   logic [7:0] ra [12] = '{ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN,
      ADDR_BLK_A, ADDR_BLK_B, ADDR_SYM_PU, ADDR_SYM_DO, ADDR_PH_PU, ADDR_PH_DO, 8'h0B};
   logic [31:0] rx [12] = '{CTRL_RST, 32'h0, 32'h0, 32'h0, 32'h0, 32'(BLK_A_RST_US),
      32'(BLK_B_RST_US), 32'h0, 32'h0, 32'(PHASE_RST_US), 32'(PHASE_RST_US), 32'h0};

   always #10 clk = ~clk;

   pct_trip_timing #(.PERSIST_CYC(PERSIST)) u_pct_trip_timing (.clk(clk), .rst(rst),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(4'hF), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .high_set_fault_detector(hi_set),
      .low_set_fault_detector(lo_set), .medium_set_detector(med), .mho_trip_function(mho_t),
      .mho_block_function(mho_b), .squared_neg_seq(sq_neg), .squared_pos_seq(sq_pos),
      .medium_set_pos_seq(med_pos), .carrier_received(carrier_rx),
      .carrier_start(carrier_start), .transmitter_key_off(key_off), .trip_out(trip),
      .transient_blocking_function(blocking), .irq(irq));

   pct_chan_model #(.DLY(1000)) u_pct_chan_model (.clk(clk), .rst(rst),
      .carrier_on(carrier_start), .key_off(key_off), .external(ext),
      .carrier_received(carrier_rx));

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one bus access held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge clk);
      end while (wait_req !== 1'b0);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic wait_for(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_for

   task automatic summarize();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (50000) @(posedge clk);
      fail_count++;
      summarize();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         bus(1'b0, ra[i], 32'h0);
         check(rv, rx[i]);
      end
      bus(1'b1, 8'h0B, 32'h0000_1234);
      bus(1'b0, 8'h0B, 32'h0);
      check(rv, 32'h0);
      bus(1'b1, ADDR_SYM_PU, 32'h0000_000A);
      bus(1'b1, ADDR_PH_PU, 32'h0000_0014);
      bus(1'b1, ADDR_PH_DO, 32'h0000_0014);
      bus(1'b1, ADDR_BLK_B, 32'h0000_0014);
      bus(1'b1, ADDR_IRQ_EN, 32'h0000_0007);
      // internal fault: both ends key off together
      @(posedge clk);
      lo_set <= 1'b1;
      sq_neg <= 1'b1;
      wait_for(carrier_start, 1'b1, 20);
      check(32'(n inside {[1:3]}), 32'h1);
      repeat (600) @(posedge clk);
      check({31'h0, key_off}, 32'h0);
      med <= 1'b1;
      wait_for(key_off, 1'b1, 2000);
      check(32'(n inside {[500:506]}), 32'h1);
      hi_set <= 1'b1;
      wait_for(trip, 1'b1, 10000);
      check(32'(n inside {[int'(PERSIST) + 1000:int'(PERSIST) + 1006]}), 32'h1);
      check({31'h0, blocking}, 32'h0);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      check(rv, 32'h0000_0005);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(rv, 32'h0000_000F);
      bus(1'b1, ADDR_IRQ_CLR, 32'h0000_0007);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      check(rv, 32'h0);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, ADDR_BLK_A, 32'h0000_000A);
      repeat (1000) @(posedge clk);
      check({31'h0, blocking}, 32'h0);
      hi_set <= 1'b0;
      lo_set <= 1'b0;
      med <= 1'b0;
      sq_neg <= 1'b0;
      repeat (3000) @(posedge clk);
      // through fault in three-phase mode: mho functions stand in
      bus(1'b1, ADDR_CTRL, 32'h0000_0003);
      @(posedge clk);
      ext <= 1'b1;
      mho_b <= 1'b1;
      med_pos <= 1'b1;
      sq_pos <= 1'b1;
      wait_for(key_off, 1'b1, 2000);
      check(32'(n inside {[500:506]}), 32'h1);
      check({31'h0, carrier_start}, 32'h1);
      repeat (2000) @(posedge clk);
      bus(1'b1, ADDR_IRQ_CLR, 32'h0000_0007);
      @(posedge clk);
      mho_t <= 1'b1;
      wait_for(blocking, 1'b1, 2000);
      check(32'(n inside {[500:506]}), 32'h1);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      check(rv, 32'h0000_0006);
      bus(1'b1, ADDR_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      mho_t <= 1'b0;
      repeat (900) @(posedge clk);
      check({31'h0, blocking}, 32'h1);
      wait_for(blocking, 1'b0, 400);
      check(32'(n inside {[100:106]}), 32'h1);
      check({31'h0, trip}, 32'h0);
      summarize();
   end
endmodule : pct_trip_timing_test
